// File: hw/slc_pkg.sv
/*
 * Constants and carrier types for the stack limit checker.
 * Assumes a 16-bit byte-addressed data space and a 16-bit word stack.
 */
package slc_pkg;
    // =========================================================
    // Widths and fixed bounds
    // =========================================================
    localparam int ADDR_W = 16;
    localparam int PC_W = 23;
    localparam logic [15:0] STACK_FLOOR = 16'h0800;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] SP_RESET = 16'h0800;
    localparam int LIM_LSB = 0;

    // Stack operation requested by the address generator
    typedef enum logic [3:0] {
        SLC_OP_NONE = 4'h1,
        SLC_OP_PUSH = 4'h2,
        SLC_OP_POP = 4'h4,
        SLC_OP_EA = 4'h8
    } slc_op_t;

    // Source of a pushed word
    typedef enum logic [1:0] {
        SLC_SRC_DATA = 2'h0,
        SLC_SRC_CALL_HI = 2'h1,
        SLC_SRC_EXC_HI = 2'h2
    } slc_src_t;

    // Request from the address generation path
    typedef struct packed {
        slc_op_t op;
        slc_src_t src;
        logic [15:0] data;
        logic [15:0] ea;
    } slc_req_t;

    // Memory access issued toward data RAM
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } slc_mem_t;

    // Secure RAM window bounds and protection enables
    typedef struct packed {
        logic boot_en;
        logic [15:0] boot_lo;
        logic [15:0] boot_hi;
        logic gen_en;
        logic [15:0] gen_lo;
        logic [15:0] gen_hi;
    } slc_sec_t;
endpackage : slc_pkg

// File: hw/slc_stack_limit_checker.sv
/*
 * Stack pointer handling, stack bound checks and secure RAM gating.
 * Assumes the CPU issues one request per cycle and accepts a one-cycle
 * trap pulse; secure window bounds are supplied as static inputs.
 */
`timescale 1ns/100ps
`default_nettype none
// How it works
// RQ1 - The stack pointer always addresses the next free word, growing up.
// RQ2 - A push writes at the pointer then increments; a pop decrements first.
// RQ3 - A call push zero-extends the counter high part to a full word.
// RQ4 - An exception push puts the status low byte above the counter high part.
// RQ5 - The limit register has no reset value until software writes it.
// RQ6 - Bit zero of the limit register is always held at zero.
// RQ7 - Every stack-pointer-based address is compared against the limit.
// RQ8 - A push at pointer equal to limit passes; the following push traps.
// RQ9 - A pointer address below the fixed floor raises an underflow trap.
// RQ10 - Software must not read through the pointer right after a limit write.
// RQ11 - Boot secure RAM is reachable only by code from boot flash when on.
// RQ12 - General secure RAM is reachable only by code from secure flash when on.
// RQ13 - Each push or pop moves the pointer by two bytes.
// RQ14 - A stack fault gives a one-cycle trap pulse and blocks the access.
module slc_stack_limit_checker (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire slc_pkg::slc_req_t req_i,
    input wire logic lim_we_i,
    input wire logic [15:0] lim_wdata_i,
    input wire logic sp_we_i,
    input wire logic [15:0] sp_wdata_i,
    input wire logic [7:0] status_low_byte_i,
    input wire logic [6:0] pc_hi_i,
    input wire logic fetch_boot_i,
    input wire logic fetch_secure_i,
    input wire slc_pkg::slc_sec_t sec_i,
    input wire logic [15:0] ram_addr_i,
    input wire logic ram_req_i,
    output logic [15:0] stack_pointer_o,
    output logic [15:0] stack_limit_o,
    output slc_pkg::slc_mem_t mem_o,
    output logic stack_trap_o,
    output logic ram_grant_o,
    output logic ram_fault_o
);
    import slc_pkg::*;

    logic [15:0] stack_pointer_register_r;
    logic [15:0] stack_limit_register_r;
    logic [15:0] push_word;
    logic [15:0] chk_addr;
    logic over_err;
    logic under_err;
    logic stack_err;
    logic is_push;
    logic is_pop;
    logic in_boot;
    logic in_gen;

    // Window membership test used for both secure segments
    function automatic logic in_win(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
        in_win = (a >= lo) && (a <= hi);
    endfunction : in_win

    // =========================================================
    // Stack bound checks
    // =========================================================
    assign is_push = (req_i.op == SLC_OP_PUSH);
    assign is_pop = (req_i.op == SLC_OP_POP);

    // Address under test: pointer itself for push, pre-decremented for pop
    always_comb begin
        unique case (req_i.op)
            SLC_OP_PUSH: chk_addr = stack_pointer_register_r; // RQ2
            SLC_OP_POP: chk_addr = stack_pointer_register_r - WORD_STEP; // RQ2
            SLC_OP_EA: chk_addr = req_i.ea; // RQ7
            SLC_OP_NONE: chk_addr = stack_pointer_register_r;
            default: chk_addr = stack_pointer_register_r;
        endcase
    end

    // Overflow only once the address under test has passed the limit
    assign over_err = (req_i.op != SLC_OP_NONE)
                      && (chk_addr > stack_limit_register_r); // RQ7 RQ8
    // A pop from a pointer already under the floor must not wrap past it
    assign under_err = (req_i.op != SLC_OP_NONE)
                       && ((chk_addr < STACK_FLOOR)
                           || (is_pop && (stack_pointer_register_r
                                          < STACK_FLOOR + WORD_STEP))); // RQ9
    assign stack_err = over_err || under_err;

    // Trap pulse, one cycle per faulting request
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            stack_trap_o <= 1'b0;
        end else begin
            stack_trap_o <= stack_err; // RQ14
        end
    end

    // =========================================================
    // Stack pointer and limit
    // =========================================================
    // Pointer moves a word per push or pop unless the access is blocked
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            stack_pointer_register_r <= SP_RESET;
        end else if (sp_we_i) begin
            stack_pointer_register_r <= {sp_wdata_i[15:1], 1'b0};
        end else if (is_push && !stack_err) begin
            stack_pointer_register_r <= stack_pointer_register_r
                                        + WORD_STEP; // RQ1 RQ2 RQ13
        end else if (is_pop && !stack_err) begin
            stack_pointer_register_r <= stack_pointer_register_r
                                        - WORD_STEP; // RQ2 RQ13
        end
    end

    // Limit has no reset branch; low bit forced clear
    always_ff @(posedge clk_i) begin
        if (lim_we_i) begin
            stack_limit_register_r <= {lim_wdata_i[15:1], 1'b0}; // RQ5 RQ6
        end
    end

    assign stack_pointer_o = stack_pointer_register_r;
    assign stack_limit_o = stack_limit_register_r;

    // =========================================================
    // Pushed word formatting
    // =========================================================
    always_comb begin
        unique case (req_i.src)
            SLC_SRC_CALL_HI: push_word = {9'h000, pc_hi_i}; // RQ3
            SLC_SRC_EXC_HI: push_word = {1'b0, status_low_byte_i,
                                         pc_hi_i}; // RQ4
            SLC_SRC_DATA: push_word = req_i.data;
            default: push_word = req_i.data;
        endcase
    end

    // Memory access registered, suppressed on a stack fault
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            mem_o <= '0;
        end else begin
            mem_o.valid <= (is_push || is_pop) && !stack_err; // RQ14
            mem_o.write <= is_push;
            mem_o.addr <= chk_addr;
            mem_o.wdata <= push_word;
        end
    end

    // =========================================================
    // Secure RAM gate
    // =========================================================
    assign in_boot = sec_i.boot_en
                     && in_win(ram_addr_i, sec_i.boot_lo, sec_i.boot_hi);
    assign in_gen = sec_i.gen_en
                    && in_win(ram_addr_i, sec_i.gen_lo, sec_i.gen_hi);

    // Grant combinational, fault a registered pulse
    assign ram_grant_o = ram_req_i
                         && !(in_boot && !fetch_boot_i) // RQ11
                         && !(in_gen && !fetch_secure_i); // RQ12

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ram_fault_o <= 1'b0;
        end else begin
            ram_fault_o <= ram_req_i && !ram_grant_o;
        end
    end

    // =========================================================
    // Checks
    // =========================================================
    property p_push_inc;
        @(posedge clk_i) disable iff (!rstn_i)
        (is_push && !stack_err && !sp_we_i) |=>
            stack_pointer_register_r
                == $past(stack_pointer_register_r) + WORD_STEP;
    endproperty
    a_push_inc: assert property (p_push_inc) else $error("push step wrong"); // RQ13

    property p_pop_dec;
        @(posedge clk_i) disable iff (!rstn_i)
        (is_pop && !stack_err && !sp_we_i) |=>
            stack_pointer_register_r
                == $past(stack_pointer_register_r) - WORD_STEP;
    endproperty
    a_pop_dec: assert property (p_pop_dec) else $error("pop step wrong"); // RQ2

    property p_lim_lsb;
        @(posedge clk_i) disable iff (!rstn_i)
        $past(lim_we_i) |-> stack_limit_register_r[0] == 1'b0;
    endproperty
    a_lim_lsb: assert property (p_lim_lsb) else $error("limit bit0 set"); // RQ6

    property p_eq_no_trap;
        @(posedge clk_i) disable iff (!rstn_i)
        (is_push && stack_pointer_register_r == stack_limit_register_r
         && stack_pointer_register_r >= STACK_FLOOR) |=> !stack_trap_o;
    endproperty
    a_eq_no_trap: assert property (p_eq_no_trap) else $error("trap at equal"); // RQ8

    property p_over_trap;
        @(posedge clk_i) disable iff (!rstn_i)
        (is_push && stack_pointer_register_r > stack_limit_register_r) |=>
            stack_trap_o ##1 (!stack_trap_o || $past(stack_err, 1));
    endproperty
    a_over_trap: assert property (p_over_trap) else $error("missed overflow"); // RQ7

    property p_under_trap;
        @(posedge clk_i) disable iff (!rstn_i)
        (is_pop && stack_pointer_register_r < STACK_FLOOR + WORD_STEP)
            |=> stack_trap_o;
    endproperty
    a_under_trap: assert property (p_under_trap) else $error("missed underflow"); // RQ9

    property p_block;
        @(posedge clk_i) disable iff (!rstn_i)
        stack_err |=> !mem_o.valid;
    endproperty
    a_block: assert property (p_block) else $error("fault not blocked"); // RQ14

    property p_call_msb;
        @(posedge clk_i) disable iff (!rstn_i)
        (is_push && req_i.src == SLC_SRC_CALL_HI) |=> mem_o.wdata[15] == 1'b0;
    endproperty
    a_call_msb: assert property (p_call_msb) else $error("call msb set"); // RQ3

    property p_exc_fmt;
        @(posedge clk_i) disable iff (!rstn_i)
        (is_push && req_i.src == SLC_SRC_EXC_HI) |=>
            mem_o.wdata[14:7] == $past(status_low_byte_i);
    endproperty
    a_exc_fmt: assert property (p_exc_fmt) else $error("status byte wrong"); // RQ4

    property p_boot_gate;
        @(posedge clk_i) disable iff (!rstn_i)
        (in_boot && !fetch_boot_i) |-> !ram_grant_o;
    endproperty
    a_boot_gate: assert property (p_boot_gate) else $error("boot ram leak"); // RQ11

    property p_gen_gate;
        @(posedge clk_i) disable iff (!rstn_i)
        (ram_req_i && in_gen && !fetch_secure_i) |=> ram_fault_o;
    endproperty
    a_gen_gate: assert property (p_gen_gate) else $error("gen ram leak"); // RQ12
endmodule : slc_stack_limit_checker
`default_nettype wire

// File: dv/slc_cpu_model.sv
/* CPU-side request model for the stack limit checker.
   Assumes requests change on falling edges of the CPU clock. */
`timescale 1ns/100ps
`default_nettype none
module slc_cpu_model (
    input wire logic clk_i,
    output slc_pkg::slc_req_t req_o,
    output logic lim_we_o,
    output logic [15:0] lim_wdata_o,
    output logic sp_we_o,
    output logic [15:0] sp_wdata_o
);
    import slc_pkg::*;
    // =====================================================
    // Idle levels
    // =====================================================
    initial begin
        req_o = '{SLC_OP_NONE, SLC_SRC_DATA, 16'h0000, 16'h0000};
        lim_we_o = 1'b0;
        lim_wdata_o = 16'h0000;
        sp_we_o = 1'b0;
        sp_wdata_o = 16'h0000;
    end
    // One request held for one edge; released data is inverted
    task automatic issue(input slc_op_t op, input slc_src_t src,
                         input logic [15:0] d, input logic [15:0] ea);
        @(negedge clk_i);
        req_o = '{op, src, d, ea};
        @(negedge clk_i);
        req_o = '{SLC_OP_NONE, src, ~d, ~ea};
    endtask : issue
    // Limit write, then an idle slot before any pointer read
    task automatic set_limit(input logic [15:0] v);
        @(negedge clk_i);
        lim_we_o = 1'b1;
        lim_wdata_o = v;
        @(negedge clk_i);
        lim_we_o = 1'b0;
        lim_wdata_o = ~v;
        @(negedge clk_i);
    endtask : set_limit
    // Direct pointer load
    task automatic load_sp(input logic [15:0] v);
        @(negedge clk_i);
        sp_we_o = 1'b1;
        sp_wdata_o = v;
        @(negedge clk_i);
        sp_we_o = 1'b0;
        sp_wdata_o = ~v;
    endtask : load_sp
endmodule : slc_cpu_model
`default_nettype wire

// File: dv/tb.sv
/* Self-checking bench for the stack limit checker.
   Assumes the CPU model drives all stack requests. */
`timescale 1ns/100ps
`default_nettype none
module tb;
    import slc_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    slc_req_t req;
    logic lim_we, sp_we;
    logic [15:0] lim_wd, sp_wd, sp, lim, ram_addr;
    logic [7:0] status_low_byte = 8'hC3;
    logic [6:0] pc_hi = 7'h7F;
    logic f_boot = 1'b0, f_sec = 1'b0, ram_req = 1'b0;
    slc_sec_t sec = '{1'b1, 16'h1000, 16'h10FF, 1'b1, 16'h2000, 16'h20FF};
    slc_mem_t mem;
    logic trap, grant, fault;
    int err_total = 0;
    int num_checks = 0;
    always #25 clk_i = ~clk_i;
    slc_stack_limit_checker u_slc_stack_limit_checker (.clk_i(clk_i),
        .rstn_i(rstn_i), .req_i(req), .lim_we_i(lim_we),
        .lim_wdata_i(lim_wd), .sp_we_i(sp_we), .sp_wdata_i(sp_wd),
        .status_low_byte_i(status_low_byte), .pc_hi_i(pc_hi), .fetch_boot_i(f_boot),
        .fetch_secure_i(f_sec), .sec_i(sec), .ram_addr_i(ram_addr),
        .ram_req_i(ram_req), .stack_pointer_o(sp), .stack_limit_o(lim),
        .mem_o(mem), .stack_trap_o(trap), .ram_grant_o(grant),
        .ram_fault_o(fault));
    slc_cpu_model u_slc_cpu_model (.clk_i(clk_i), .req_o(req),
        .lim_we_o(lim_we), .lim_wdata_o(lim_wd), .sp_we_o(sp_we),
        .sp_wdata_o(sp_wd));
    // =====================================================
    // Checking helpers
    // =====================================================
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Issue one request and judge trap, memory access and pointer
    task automatic op(input slc_op_t o, input slc_src_t s,
        input logic [15:0] d, input logic [15:0] ea, input logic t,
        input logic [15:0] a, input logic [15:0] wd, input logic [15:0] e);
        u_slc_cpu_model.issue(o, s, d, ea);
        chk("trap", {15'h0, t}, {15'h0, trap});
        chk("pointer", e, sp);
        if (o != SLC_OP_EA) begin
            chk("valid", {15'h0, ~t}, {15'h0, mem.valid});
            if (!t) begin
                chk("addr", a, mem.addr);
                chk("write", {15'h0, o == SLC_OP_PUSH}, {15'h0, mem.write});
                if (o == SLC_OP_PUSH) chk("wdata", wd, mem.wdata);
            end
        end
    endtask : op
    task automatic ram(input logic [15:0] a, input logic b, input logic s,
                       input logic g);
        @(negedge clk_i);
        ram_addr = a;
        f_boot = b;
        f_sec = s;
        ram_req = 1'b1;
        #1 chk("grant", {15'h0, g}, {15'h0, grant});
        @(negedge clk_i);
        ram_req = 1'b0;
        chk("fault", {15'h0, ~g}, {15'h0, fault});
    endtask : ram
    // =====================================================
    // Scenarios
    // =====================================================
    task automatic t_push;
        chk("sp_reset", 16'h0800, sp);
        u_slc_cpu_model.set_limit(16'h0901);
        chk("limit", 16'h0900, lim);
        op(SLC_OP_PUSH, SLC_SRC_DATA, 16'hA5A5, 0, 0, 16'h0800, 16'hA5A5,
           16'h0802);
        op(SLC_OP_PUSH, SLC_SRC_CALL_HI, 0, 0, 0, 16'h0802, 16'h007F,
           16'h0804);
        op(SLC_OP_PUSH, SLC_SRC_EXC_HI, 0, 0, 0, 16'h0804, 16'h61FF,
           16'h0806);
        op(SLC_OP_POP, SLC_SRC_DATA, 0, 0, 0, 16'h0804, 0, 16'h0804);
        $display("test push_pop done");
    endtask : t_push
    task automatic t_limit;
        u_slc_cpu_model.load_sp(16'h0900);
        op(SLC_OP_PUSH, SLC_SRC_DATA, 16'h1234, 0, 0, 16'h0900, 16'h1234,
           16'h0902);
        op(SLC_OP_PUSH, SLC_SRC_DATA, 16'h4321, 0, 1, 0, 0, 16'h0902);
        @(negedge clk_i);
        chk("trap_pulse", 16'h0, {15'h0, trap});
        op(SLC_OP_EA, SLC_SRC_DATA, 0, 16'h0900, 0, 0, 0, 16'h0902);
        op(SLC_OP_EA, SLC_SRC_DATA, 0, 16'h0902, 1, 0, 0, 16'h0902);
        $display("test limit done");
    endtask : t_limit
    task automatic t_floor;
        u_slc_cpu_model.load_sp(16'h0800);
        op(SLC_OP_POP, SLC_SRC_DATA, 0, 0, 1, 0, 0, 16'h0800);
        op(SLC_OP_EA, SLC_SRC_DATA, 0, 16'h07FE, 1, 0, 0, 16'h0800);
        $display("test floor done");
    endtask : t_floor
    task automatic t_secure;
        ram(16'h1000, 0, 0, 0);
        ram(16'h10FF, 1, 0, 1);
        ram(16'h2000, 1, 0, 0);
        ram(16'h20FF, 0, 1, 1);
        ram(16'h3000, 0, 0, 1);
        // Protection off: both windows open to any code
        sec = '{1'b0, 16'h1000, 16'h10FF, 1'b0, 16'h2000, 16'h20FF};
        ram(16'h1000, 0, 0, 1);
        ram(16'h2000, 0, 0, 1);
        $display("test secure done");
    endtask : t_secure
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict
    // Reset, then every scenario in turn
    initial begin
        ram_addr = 16'h0000;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        rstn_i = 1'b1;
        t_push();
        t_limit();
        t_floor();
        t_secure();
        give_verdict();
    end
    // Hang guard
    initial begin
        repeat (4000) @(posedge clk_i);
        err_total++;
        give_verdict();
    end
endmodule : tb
`default_nettype wire
